//--- core/fec_inj_pkg.sv
// Purpose: shared constants for the transmit FEC error-injection control block
// Assumes: register addresses are word offsets on a plain 12-bit address port
// Notes: identification values live as parameters of the top module
package fec_inj_pkg;
    // register map
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] A_REVISION = 12'hC00;
    localparam logic [11:0] A_IDENT0 = 12'hC01;
    localparam logic [11:0] A_IDENT1 = 12'hC02;
    localparam logic [11:0] A_IDENT2 = 12'hC03;
    localparam logic [11:0] A_INJ_CTL = 12'hC04;
    localparam logic [11:0] A_INJ_PAT = 12'hC05;
    localparam logic [11:0] A_PASS = 12'hC06;

    // control word and pass-through word fields
    localparam int CTL_CONT_BIT = 0;
    localparam int CTL_SINGLE_BIT = 4;
    localparam int PASS_BIT = 0;

    // pattern word fields
    localparam int BIT_MASK_LSB = 16;
    localparam int BIT_MASK_W = 10;
    localparam int SYM_MASK_LSB = 8;
    localparam int SYM_MASK_W = 8;
    localparam int GROUP_SEL_LSB = 0;
    localparam int GROUP_SEL_W = 7;

    // codeword geometry
    localparam int SYM_W = 10;
    localparam int SYMS_PER_GROUP = 8;
    localparam int SYMS_PER_CW = 528;
    localparam int GROUP_W = SYM_W * SYMS_PER_GROUP;
    localparam int GROUPS_PER_CW = SYMS_PER_CW / SYMS_PER_GROUP;
    localparam logic [6:0] LAST_GROUP = 7'(GROUPS_PER_CW - 1);

    // reset values
    localparam logic [9:0] BIT_MASK_RST = 10'h000;
    localparam logic [7:0] SYM_MASK_RST = 8'h00;
    localparam logic [6:0] GROUP_SEL_RST = 7'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // buffering
    localparam int FIFO_DEPTH = 8;
endpackage

//--- core/stream_fifo.sv
// Purpose: small synchronous FIFO with registered flags and registered read data
// Assumes: one clock, synchronous active-high reset
// Notes: a pop is one word per cycle; in_ready drops at the same edge as the last slot fills
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic in_ready;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_st_t;

    fifo_st_t q, d;
    logic push, pop;

    assign in_ready = q.in_ready;
    assign out_valid = q.out_valid;
    assign out_data = q.out_data;

    // push on handshake, refill the output register whenever it is free
    always_comb
    begin
        d = q;
        push = in_valid && q.in_ready;
        pop = (q.count != '0) && (!q.out_valid || out_ready);
        if (q.out_valid && out_ready)
        begin
            d.out_valid = 1'b0;
        end
        if (pop)
        begin
            d.out_data = q.mem[q.rd_ptr];
            d.out_valid = 1'b1;
            d.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
        end
        if (push)
        begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
        end
        d.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
        // flag from the next count, so a full store never takes one more word
        d.in_ready = (d.count < (PW+1)'(DEPTH));
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            q <= '0;
            q.in_ready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end
endmodule

//--- core/rsfec_tx_error_injection_ctrl.sv
// Purpose: identification, pass-through control and error injection for the tx FEC path
// Assumes: one 80-bit group per accepted beat, first beat after reset is group 0
// Notes: injected groups and clean groups both pass through an 8-word FIFO
`timescale 1ns/1ps
module rsfec_tx_error_injection_ctrl
    import fec_inj_pkg::*;
#(
    parameter logic [31:0] REV_ID = 32'h0001_0000, // arbitrary value
    parameter logic [31:0] IDENT_W0 = 32'h7478_6665, // arbitrary value
    parameter logic [31:0] IDENT_W1 = 32'h635F_696E, // arbitrary value
    parameter logic [31:0] IDENT_W2 = 32'h6A65_6374, // arbitrary value
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    // group stream from the encoder
    input wire logic [GROUP_W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // group stream towards the transceiver
    output logic [GROUP_W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // shared pass-through level to the tx and rx FEC cores
    output logic fec_bypass
);
    typedef struct packed {
        logic ctl_cont;
        logic ctl_single;
        logic [BIT_MASK_W-1:0] bit_mask;
        logic [SYM_MASK_W-1:0] sym_mask;
        logic [GROUP_SEL_W-1:0] group_sel;
        logic bypass;
        logic [GROUP_SEL_W-1:0] grp_cnt;
        logic [DATA_W-1:0] rd_data;
    } ctl_st_t;

    ctl_st_t q, d;
    logic fifo_ready;
    logic accept;
    logic inject_en;
    logic hit;
    logic [GROUP_W-1:0] flip_mask;
    logic [GROUP_W-1:0] fifo_in_data;

    // identification lookup, used by the read mux and by its checks
    function automatic logic [DATA_W-1:0] ident_word(input logic [ADDR_W-1:0] a);
        if (a == A_IDENT0)
        begin
            return IDENT_W0;
        end
        else if (a == A_IDENT1)
        begin
            return IDENT_W1;
        end
        else if (a == A_IDENT2)
        begin
            return IDENT_W2;
        end
        else
        begin
            return WORD_ZERO;
        end
    endfunction

    // each enabled symbol gets the bit mask, symbol 0 in the low bits
    genvar s;
    generate
        for (s = 0; s < SYMS_PER_GROUP; s++)
        begin : g_sym
            assign flip_mask[s*SYM_W +: SYM_W] =
                q.sym_mask[s] ? q.bit_mask : '0;
        end
    endgenerate

    // a group out of range 0-65 never matches the counter, so nothing is hit
    assign accept = in_valid && fifo_ready;
    assign inject_en = !q.bypass && (q.ctl_cont || q.ctl_single)
        && (q.grp_cnt == q.group_sel);
    assign hit = accept && inject_en;
    assign fifo_in_data = hit ? (in_data ^ flip_mask) : in_data;

    assign rd_data = q.rd_data;
    assign fec_bypass = q.bypass;

    // register writes, reads, group counting and single-shot handling
    always_comb
    begin
        d = q;
        d.rd_data = WORD_ZERO;
        // count groups through a codeword, wrapping after the last
        if (accept)
        begin
            d.grp_cnt = (q.grp_cnt == LAST_GROUP) ? '0 : q.grp_cnt + 1'b1;
        end
        // self-clear after the corrupted group has been taken
        if (hit && q.ctl_single)
        begin
            d.ctl_single = 1'b0;
        end
        // a write lands after the clear, so a new arm in that cycle is kept
        if (wr_en)
        begin
            if (addr == A_INJ_CTL)
            begin
                d.ctl_cont = wr_data[CTL_CONT_BIT];
                d.ctl_single = wr_data[CTL_SINGLE_BIT]; // a zero disarms
            end
            else if (addr == A_INJ_PAT)
            begin
                d.bit_mask = wr_data[BIT_MASK_LSB +: BIT_MASK_W];
                d.sym_mask = wr_data[SYM_MASK_LSB +: SYM_MASK_W];
                d.group_sel = wr_data[GROUP_SEL_LSB +: GROUP_SEL_W];
            end
            else if (addr == A_PASS)
            begin
                d.bypass = wr_data[PASS_BIT];
            end
        end
        // read data stand for one cycle only; unmapped reads return zero
        if (rd_en)
        begin
            if (addr == A_REVISION)
            begin
                d.rd_data = REV_ID;
            end
            else if (addr == A_INJ_CTL)
            begin
                d.rd_data[CTL_CONT_BIT] = q.ctl_cont;
                d.rd_data[CTL_SINGLE_BIT] = q.ctl_single;
            end
            else if (addr == A_INJ_PAT)
            begin
                d.rd_data[BIT_MASK_LSB +: BIT_MASK_W] = q.bit_mask;
                d.rd_data[SYM_MASK_LSB +: SYM_MASK_W] = q.sym_mask;
                d.rd_data[GROUP_SEL_LSB +: GROUP_SEL_W] = q.group_sel;
            end
            else if (addr == A_PASS)
            begin
                d.rd_data[PASS_BIT] = q.bypass;
            end
            else
            begin
                d.rd_data = ident_word(addr);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            q <= '0;
            q.bit_mask <= BIT_MASK_RST;
            q.sym_mask <= SYM_MASK_RST;
            q.group_sel <= GROUP_SEL_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // output buffer; its full flag stalls the encoder through in_ready
    stream_fifo #(
        .WIDTH(GROUP_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_data(fifo_in_data),
        .in_valid(in_valid),
        .in_ready(fifo_ready),
        .out_data(out_data),
        .out_valid(out_valid),
        .out_ready(out_ready)
    );
    assign in_ready = fifo_ready;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    revision_read_a: assert property (
        rd_en && addr == A_REVISION |=> rd_data == REV_ID)
        else $error("revision word wrong");

    ident_read_a: assert property (
        rd_en && (addr == A_IDENT0 || addr == A_IDENT1 || addr == A_IDENT2)
        |=> rd_data == ident_word($past(addr)) && rd_data != WORD_ZERO)
        else $error("identifier word wrong");

    single_clear_a: assert property (
        hit && q.ctl_single && !wr_en |=> !q.ctl_single ##1 (!q.ctl_single || $past(wr_en)))
        else $error("single shot did not clear");

    cont_inject_a: assert property (
        accept && q.ctl_cont && !q.bypass && q.grp_cnt == q.group_sel
        |-> fifo_in_data == (in_data ^ flip_mask))
        else $error("continuous injection missed");

    group_wrap_a: assert property (
        accept && q.grp_cnt == LAST_GROUP |=> q.grp_cnt == '0)
        else $error("group count did not wrap at 65");

    group_step_a: assert property (
        accept && q.grp_cnt < LAST_GROUP |=> q.grp_cnt == $past(q.grp_cnt) + 1'b1)
        else $error("group count did not step");

    group_range_a: assert property (
        q.grp_cnt <= LAST_GROUP)
        else $error("group count out of range");

    pattern_write_a: assert property (
        wr_en && addr == A_INJ_PAT |=> q.bit_mask == $past(wr_data[25:16])
        && q.sym_mask == $past(wr_data[15:8]) && q.group_sel == $past(wr_data[6:0]))
        else $error("pattern fields not stored");

    far_group_a: assert property (
        q.group_sel > LAST_GROUP |-> !hit)
        else $error("injection on invalid group");

    bypass_out_a: assert property (
        wr_en && addr == A_PASS |=> fec_bypass == $past(wr_data[PASS_BIT])
        ##1 (fec_bypass == $past(fec_bypass) || $past(wr_en)))
        else $error("bypass level wrong");

    clean_pass_a: assert property (
        accept && !hit |-> fifo_in_data == in_data)
        else $error("untargeted group altered");

    reserved_zero_a: assert property (
        rd_en && addr == A_INJ_CTL |=> rd_data[31:5] == '0 && rd_data[3:1] == '0)
        else $error("reserved control bits not zero");

    // control word holds what software wrote, until the next write or a hit
    ctl_store_a: assert property (
        wr_en && addr == A_INJ_CTL |=> q.ctl_cont == $past(wr_data[CTL_CONT_BIT]))
        else $error("continuous bit not stored");

    single_arm_a: assert property (
        wr_en && addr == A_INJ_CTL |=> q.ctl_single == $past(wr_data[CTL_SINGLE_BIT]))
        else $error("single shot bit not stored");

    single_hold_a: assert property (
        q.ctl_single && !hit && !wr_en |=> q.ctl_single)
        else $error("single shot dropped before its group");

    cont_hold_a: assert property (
        !wr_en |=> q.ctl_cont == $past(q.ctl_cont))
        else $error("continuous bit changed without a write");

    single_inject_a: assert property (
        accept && q.ctl_single && !q.bypass && q.grp_cnt == q.group_sel
        |-> fifo_in_data == (in_data ^ flip_mask))
        else $error("single shot injection missed");

    // the flipped bit count is fixed by the two masks, whatever the data
    flip_count_a: assert property (
        hit |-> $countones(fifo_in_data ^ in_data)
        == $countones(q.bit_mask) * $countones(q.sym_mask))
        else $error("wrong number of bits flipped");

    idle_clean_a: assert property (
        accept && !q.ctl_cont && !q.ctl_single |-> fifo_in_data == in_data)
        else $error("group altered while disarmed");

    group_hold_a: assert property (
        !accept |=> q.grp_cnt == $past(q.grp_cnt))
        else $error("group count moved without a beat");

    // pass-through wins over any armed injection
    bypass_block_a: assert property (
        q.bypass |-> !hit)
        else $error("injection while bypassed");

    bypass_hold_a: assert property (
        !wr_en |=> fec_bypass == $past(fec_bypass))
        else $error("bypass changed without a write");

    pat_reserved_a: assert property (
        rd_en && addr == A_INJ_PAT |=> rd_data[31:26] == '0 && rd_data[7] == 1'b0)
        else $error("reserved pattern bits not zero");

    pass_reserved_a: assert property (
        rd_en && addr == A_PASS |=> rd_data[31:1] == '0)
        else $error("reserved bypass bits not zero");

    unmapped_zero_a: assert property (
        rd_en && (addr < A_REVISION || addr > A_PASS) |=> rd_data == WORD_ZERO)
        else $error("unmapped read not zero");
endmodule

//--- tb/group_sink.sv
// Purpose: behavioural transceiver side that takes groups from the block
// Assumes: the bench may hold stall high to model a slow lane
// Notes: each accepted group is reported one cycle later on got and got_data
`timescale 1ns/1ps
module group_sink
    import fec_inj_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // group stream from the block
    input wire logic [GROUP_W-1:0] out_data,
    input wire logic out_valid,
    output logic out_ready,
    // bench side
    input wire logic stall,
    output logic got,
    output logic [GROUP_W-1:0] got_data
);
    // ready follows stall one cycle late, as a real lane would react
    always @(posedge mclk)
    begin
        out_ready <= !stall && !reset;
        got <= out_valid && out_ready && !reset;
        got_data <= out_data;
    end
endmodule

//--- tb/rsfec_tx_error_injection_ctrl_test.sv
// Purpose: register and stream tests for the tx FEC error-injection block
// Assumes: word addresses, read data only in the cycle after the strobe
// Notes: expected groups are rebuilt here from the pattern fields
`timescale 1ns/1ps
module rsfec_tx_error_injection_ctrl_test;
    import fec_inj_pkg::*;
    localparam logic [31:0] REV = 32'h0A0B_0C0D; // arbitrary value
    localparam logic [31:0] ID0 = 32'h6162_6364; // arbitrary value
    localparam logic [31:0] ID1 = 32'h6566_6768; // arbitrary value
    localparam logic [31:0] ID2 = 32'h696A_6B6C; // arbitrary value
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic in_valid = 1'b0;
    logic stall = 1'b0;
    logic [GROUP_W-1:0] in_data = '0;
    logic [DATA_W-1:0] rd_data;
    logic in_ready, out_valid, out_ready, fec_bypass, got;
    logic [GROUP_W-1:0] out_data, got_data;
    logic [GROUP_W-1:0] exp_q[$];
    logic [9:0] bm = '0;
    logic [7:0] sm = '0;
    logic [6:0] gs = '0;
    logic single = 1'b0, cont = 1'b0, byp = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    int gcount = 0;
    int k = 0;

    // 10 MHz clock
    always #50 mclk = ~mclk;

    rsfec_tx_error_injection_ctrl #(.REV_ID(REV), .IDENT_W0(ID0), .IDENT_W1(ID1),
        .IDENT_W2(ID2), .DEPTH(FIFO_DEPTH)) DUT (.mclk(mclk), .reset(reset),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .fec_bypass(fec_bypass));

    group_sink SINK (.mclk(mclk), .reset(reset), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready), .stall(stall), .got(got),
        .got_data(got_data));

    task end_of_test;
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [GROUP_W-1:0] act, input logic [GROUP_W-1:0] exp, input string m);
        checks_done++;
        if (act !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask

    // data checked in the one cycle it stands, then must be back at zero
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 chk(80'(rd_data), 80'(e), "read data");
        @(posedge mclk);
        #1 chk(80'(rd_data), 80'(0), "read data after its cycle");
    endtask

    // own model of the corruption: flip masked bits of masked symbols
    function automatic logic [GROUP_W-1:0] hit(input logic [GROUP_W-1:0] d);
        for (int s = 0; s < 8; s++)
            if (sm[s])
                d[s*10 +: 10] = d[s*10 +: 10] ^ bm;
        return d;
    endfunction

    // back-to-back beats; valid held until in_ready is seen at an edge
    task send(input int n);
        logic [GROUP_W-1:0] d;
        @(posedge mclk);
        for (int i = 0; i < n; i++)
        begin
            d = {5{16'(k)}};
            in_valid <= 1'b1;
            in_data <= d;
            do @(posedge mclk); while (in_ready !== 1'b1);
            if (!byp && (cont || single) && gcount == int'(gs))
            begin
                d = hit(d);
                single = 1'b0;
            end
            exp_q.push_back(d);
            gcount = (gcount == 65) ? 0 : gcount + 1;
            k++;
        end
        in_valid <= 1'b0;
        in_data <= ~d;
    endtask

    task drain;
        for (int i = 0; i < 300 && exp_q.size() > 0; i++)
            @(posedge mclk);
        chk(80'(exp_q.size()), 80'(0), "groups not delivered");
    endtask

    // every group that leaves must be the next expected one
    always @(posedge mclk)
        if (got === 1'b1)
            chk(got_data, exp_q.size() > 0 ? exp_q.pop_front() : ~got_data, "group");

    initial
    begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(A_REVISION, REV);
        rd(A_IDENT0, ID0);
        rd(A_IDENT1, ID1);
        rd(A_IDENT2, ID2);
        rd(A_INJ_CTL, WORD_ZERO);
        rd(A_INJ_PAT, WORD_ZERO);
        rd(A_PASS, WORD_ZERO);
        rd(12'hC07, WORD_ZERO);
        wr(A_REVISION, 32'hFFFF_FFFF);
        rd(A_REVISION, REV);
        wr(A_INJ_CTL, 32'hFFFF_FFFF);
        rd(A_INJ_CTL, 32'h0000_0011);
        wr(A_INJ_CTL, WORD_ZERO);
        rd(A_INJ_CTL, WORD_ZERO);
        wr(A_INJ_PAT, 32'hFFFF_FFFF);
        rd(A_INJ_PAT, 32'h03FF_FF7F);
        wr(A_PASS, 32'hFFFF_FFFF);
        chk(80'(fec_bypass), 80'(1), "bypass level");
        rd(A_PASS, 32'h0000_0001);
        wr(A_PASS, WORD_ZERO);
        chk(80'(fec_bypass), 80'(0), "bypass released");
        // single shot on the last group, over two codewords
        sm = 8'h81;
        bm = 10'h201;
        gs = LAST_GROUP;
        wr(A_INJ_PAT, {6'h00, bm, sm, 1'b0, gs});
        wr(A_INJ_CTL, 32'h0000_0010);
        single = 1'b1;
        send(132);
        drain;
        rd(A_INJ_CTL, WORD_ZERO);
        // continuous on group 0, lane stalled until the fifo refuses
        sm = 8'h3C;
        bm = 10'h3FF;
        gs = 7'h00;
        wr(A_INJ_PAT, {6'h00, bm, sm, 1'b0, gs});
        wr(A_INJ_CTL, 32'h0000_0001);
        cont = 1'b1;
        stall <= 1'b1;
        fork
            send(132);
        join_none
        repeat (24) @(posedge mclk);
        #1 chk(80'(in_ready), 80'(0), "ready with full fifo");
        chk(80'(out_valid), 80'(1), "output held while stalled");
        stall <= 1'b0;
        wait fork;
        drain;
        // pass-through suppresses injection, then clearing stops it
        wr(A_PASS, 32'h0000_0001);
        byp = 1'b1;
        send(66);
        drain;
        wr(A_PASS, WORD_ZERO);
        byp = 1'b0;
        wr(A_INJ_CTL, WORD_ZERO);
        cont = 1'b0;
        send(66);
        drain;
        end_of_test;
    end

    // watchdog well beyond the roughly 530 cycles the tests need
    initial
    begin
        #(100 * 20000);
        err_total++;
        end_of_test;
    end
endmodule
